// ==== core/dbo_ctrl.sv ====
// Controller end: request queue, command scheduling, write drive, termination
// What this block does
// - Fixed eight, or per-command A12 high: eight beats
// - Fixed chop, or per-command with A12 low: four
// - Read latency is CAS plus additive latency
// - Write data driven write latency after command
// - Read waits write-to-read time after write data
// - Precharge waits write recovery after write data
// - Chopped write timers start as for full burst
// - Termination stays high at least short hold
// - Termination held short or long after write
// - Both termination hold references met before release
// - Active power-down entry follows only permitted commands
// - Power-down edges: idle, then DLL-free, then rest
// - Read strobe held low between reads while the next read is already pending
// - Each read picks its own burst length
`timescale 1ns/1ps
module dbo_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // Clock, reset and freeze
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rp, wp;
  logic [AW:0] count;

  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;
  wire logic [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = count != '0;
  assign out_data = mem[rp];

  // Depth must be a power of two so the pointers wrap by themselves
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {rp, wp, count} <= '0;
      in_ready <= 1'b1;
    end else if (clk_en) begin
      rp <= rp + AW'(pop);
      wp <= wp + AW'(push);
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && push) mem[wp] <= in_data;
  end
endmodule : dbo_fifo

module dbo_ctrl (
  // Clock, reset and freeze
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Configuration, must match the memory's mode registers
  input wire logic [1:0] mode_burst,
  input wire logic [1:0] mode_al,
  input wire logic odt_en,
  // Requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_op,
  input wire logic req_chop,
  input wire logic [2:0] req_bank,
  input wire logic [3:0] req_col,
  input wire logic [15:0] req_data,
  // Power-down request
  input wire logic pd_req,
  output logic in_powerdown,
  // Read return
  output logic rd_valid,
  output logic [15:0] rd_data,
  // Link
  dbo_if.ctrl link
);
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [1:0] OP_RD = 2'h0;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_ACT = 2'h2;
  localparam logic [1:0] OP_PRE = 2'h3;
  typedef enum logic [2:0] {ST_RUN = 3'b001, ST_DOWN = 3'b010, ST_EXIT = 3'b100} dbo_st_e;

  dbo_st_e state, next_state;
  logic q_valid;
  logic issue;
  logic [25:0] q_word;
  logic [7:0] gap, wtr, twr, xp, dll, odt_cnt, wd_wait;
  logic [4:0] anpd;
  logic [2:0] wbeat;
  logic wact, w_is8, p_is8;
  logic [15:0] w_seed, p_seed;

  function automatic logic [7:0] dec(input logic [7:0] v);
    return (v != 8'h00) ? v - 8'h01 : 8'h00;
  endfunction : dec

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction : max8

  ////////////////////////////////////////////////////////////////////////////
  // Queue stalls under a power-down request, so back-pressure reaches the user
  dbo_fifo #(.WIDTH(26), .DEPTH(8)) u_queue (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_op, req_chop, req_bank, req_col, req_data}),
    .out_valid(q_valid),
    .out_ready(issue),
    .out_data(q_word)
  );

  wire logic [1:0] q_op = q_word[25:24];
  wire logic q_chop = q_word[23];
  wire logic [4:0] wl = dbo_pkg::write_lat(mode_al);
  // In per-command mode A12 carries the length of this command alone
  wire logic a12_out = ~q_chop;
  wire logic q_is8 = dbo_pkg::burst_is8(mode_burst, a12_out);
  // Chopped bursts still count their full eight-slot span for the timers
  wire logic [7:0] wl8 = 8'(wl) + dbo_pkg::BEATS_FULL;
  wire logic [7:0] odth = q_is8 ? dbo_pkg::HOLD_LONG_CYC : dbo_pkg::HOLD_SHORT_CYC;
  wire logic [7:0] odt_len = max8(wl8, max8(odth, dbo_pkg::HOLD_SHORT_CYC));
  wire logic rd_ok = (gap == 8'h00) & (wtr == 8'h00) & (dll == 8'h00);
  wire logic wr_ok = (gap == 8'h00) & (dll == 8'h00) & (~odt_en | (anpd == 5'h00));
  wire logic pre_ok = twr == 8'h00;
  wire logic op_ok = (q_op == OP_RD) ? rd_ok : (q_op == OP_WR) ? wr_ok : (q_op == OP_PRE) ? pre_ok : 1'b1;
  assign issue = (state == ST_RUN) & ~pd_req & q_valid & op_ok;
  wire logic issue_wr = issue & (q_op == OP_WR);
  wire logic issue_col = issue & ~q_op[1];
  wire logic quiet = (gap == 8'h00) & (twr == 8'h00) & (odt_cnt == 8'h00) & ~wact & (wd_wait == 8'h00);
  // Entry only from quiet, so the prior command was ACT, PRE or NOP
  wire logic pd_enter = (state == ST_RUN) & pd_req & quiet;
  wire logic pd_leave = (state == ST_DOWN) & ~pd_req;
  wire logic wd_go = wd_wait == 8'h01;
  wire logic next_wact = wd_go | (wact & (wbeat != 3'h7));
  wire logic [2:0] next_wbeat = wd_go ? 3'h0 : wbeat + 3'h1;
  wire logic next_w_is8 = wd_go ? p_is8 : w_is8;
  wire logic [15:0] next_seed = wd_go ? p_seed : w_seed;
  wire logic wdrive = next_wact & (next_w_is8 | ~next_wbeat[2]);
  wire logic next_odt = (issue_wr & odt_en) | (odt_cnt > 8'h01);

  always_comb begin
    case (state)
      ST_RUN: next_state = pd_enter ? ST_DOWN : ST_RUN;
      ST_DOWN: next_state = pd_leave ? ST_EXIT : ST_DOWN;
      ST_EXIT: next_state = (xp == 8'h00) ? ST_RUN : ST_EXIT;
      default: next_state = ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {gap, wtr, twr, xp, dll, odt_cnt, wd_wait} <= '0;
      anpd <= 5'h00;
    end else if (clk_en) begin
      gap <= issue_col ? dbo_pkg::COL_GAP : dec(gap);
      wtr <= issue_wr ? wl8 + dbo_pkg::WTR_CYC : dec(wtr);
      twr <= issue_wr ? wl8 + dbo_pkg::WR_CYC : dec(twr);
      xp <= pd_leave ? dbo_pkg::XP_CYC : dec(xp);
      dll <= pd_leave ? dbo_pkg::XPDLL_CYC : dec(dll);
      // A write while termination is high restarts the hold from that write
      odt_cnt <= (issue_wr & odt_en) ? max8(odt_cnt, odt_len) : dec(odt_cnt);
      wd_wait <= issue_wr ? 8'(wl) : dec(wd_wait);
      anpd <= (pd_enter | pd_leave) ? wl - 5'h01 : 5'(dec(8'(anpd)));
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {wact, wbeat, w_is8, w_seed, p_is8, p_seed} <= '0;
    end else if (clk_en) begin
      {wact, wbeat, w_is8, w_seed} <= {next_wact, next_wbeat, next_w_is8, next_seed};
      if (issue_wr) {p_is8, p_seed} <= {q_is8, q_word[15:0]};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.cmd <= dbo_pkg::CMD_NOP;
      {link.a12, link.bank, link.col} <= '0;
      link.cke <= 1'b1;
      link.odt <= 1'b0;
    end else if (clk_en) begin
      // Only NOP goes out in the exit window and while down
      link.cmd <= issue ? ((q_op == OP_RD) ? dbo_pkg::CMD_RD : (q_op == OP_WR) ? dbo_pkg::CMD_WR :
                  (q_op == OP_ACT) ? dbo_pkg::CMD_ACT : dbo_pkg::CMD_PRE) : dbo_pkg::CMD_NOP;
      {link.a12, link.bank, link.col} <= {a12_out, q_word[22:16]};
      link.cke <= (next_state != ST_DOWN);
      link.odt <= next_odt & (state == ST_RUN);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.ctrl_dq <= '0;
      {link.ctrl_dq_oe, link.ctrl_dqs, link.ctrl_dqs_oe} <= '0;
    end else if (clk_en) begin
      link.ctrl_dq <= wdrive ? next_seed + 16'(next_wbeat) : '0;
      link.ctrl_dq_oe <= wdrive;
      link.ctrl_dqs <= wdrive & ~next_wbeat[0];
      link.ctrl_dqs_oe <= wdrive;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_RUN;
      in_powerdown <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (clk_en) begin
      state <= next_state;
      in_powerdown <= next_state == ST_DOWN;
      rd_valid <= link.dram_dq_oe;
      rd_data <= link.dq;
    end
  end
endmodule : dbo_ctrl

// ==== pkg/dbo_pkg.sv ====
// Shared constants, command codes and latency helpers for both link ends
package dbo_pkg;
  localparam int CLK_PS = 5000;
  localparam int DQ_W = 16;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4,
    CMD_DES = 3'h7
  } dbo_cmd_e;

  // Burst field of the first mode register
  localparam logic [1:0] BURST_FIX8 = 2'h0;
  localparam logic [1:0] BURST_PER_CMD = 2'h1;
  localparam logic [1:0] BURST_CHOP4 = 2'h2;
  // Additive latency selection
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CLM1 = 2'h1;
  localparam logic [1:0] AL_CLM2 = 2'h2;

  localparam logic [4:0] CAS_LAT = 5'h05;
  localparam logic [4:0] CAS_WLAT = 5'h05;
  localparam logic [7:0] BEATS_FULL = 8'h08;
  localparam logic [7:0] COL_GAP = 8'h0A;
  localparam logic [7:0] HOLD_SHORT_CYC = 8'h04;
  localparam logic [7:0] HOLD_LONG_CYC = 8'h06;

  localparam int T_WR_PS = 15000;
  localparam int T_WTR_PS = 7500;
  localparam int T_XP_PS = 6000;
  localparam int T_XPDLL_PS = 24000;
  localparam logic [7:0] WR_CYC = 8'((T_WR_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] WTR_CYC = 8'((T_WTR_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] XP_CYC = 8'((T_XP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] XPDLL_CYC = 8'((T_XPDLL_PS + CLK_PS - 1) / CLK_PS);

  function automatic logic burst_is8(input logic [1:0] mode, input logic a12);
    return (mode == BURST_FIX8) | ((mode == BURST_PER_CMD) & a12);
  endfunction : burst_is8

  function automatic logic [4:0] add_lat(input logic [1:0] al);
    return (al == AL_CLM1) ? CAS_LAT - 5'h01 : (al == AL_CLM2) ? CAS_LAT - 5'h02 : 5'h00;
  endfunction : add_lat

  function automatic logic [4:0] read_lat(input logic [1:0] al);
    return CAS_LAT + add_lat(al);
  endfunction : read_lat

  function automatic logic [4:0] write_lat(input logic [1:0] al);
    return CAS_WLAT + add_lat(al);
  endfunction : write_lat
endpackage : dbo_pkg

// ==== pkg/dbo_if.sv ====
// Command, termination and data link between controller and memory
`timescale 1ns/1ps
interface dbo_if;
  dbo_pkg::dbo_cmd_e cmd;
  logic cke;
  logic odt;
  logic a12;
  logic [2:0] bank;
  logic [3:0] col;
  logic [dbo_pkg::DQ_W-1:0] ctrl_dq;
  logic ctrl_dq_oe;
  logic ctrl_dqs;
  logic ctrl_dqs_oe;
  logic [dbo_pkg::DQ_W-1:0] dram_dq;
  logic dram_dq_oe;
  logic dram_dqs;
  logic dram_dqs_oe;
  logic [dbo_pkg::DQ_W-1:0] dq;
  logic dqs;

  // Shared wires resolved from the two enables; an idle bus reads zero
  assign dq = ctrl_dq_oe ? ctrl_dq : (dram_dq_oe ? dram_dq : '0);
  assign dqs = ctrl_dqs_oe ? ctrl_dqs : (dram_dqs_oe & dram_dqs);

  modport ctrl (output cmd, cke, odt, a12, bank, col, ctrl_dq, ctrl_dq_oe, ctrl_dqs, ctrl_dqs_oe,
                input dq, dqs, dram_dq_oe, dram_dqs_oe);
  modport dram (input cmd, cke, odt, a12, bank, col, dq, dqs, ctrl_dq_oe,
                output dram_dq, dram_dq_oe, dram_dqs, dram_dqs_oe);
endinterface : dbo_if

// ==== core/dbo_dram.sv ====
// Memory end: burst decode, latency pipes, read drive and termination state
`timescale 1ns/1ps
module dbo_dram #(
  parameter int ADDR_W = 7
) (
  // Clock, reset and freeze
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Mode register contents
  input wire logic [1:0] mode_burst,
  input wire logic [1:0] mode_al,
  // Link
  dbo_if.dram link,
  // Status
  output logic powered_down,
  output logic term_on,
  output logic term_dynamic,
  output logic term_uncertain
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic v;
    logic wr;
    logic is8;
    logic [2:0] bank;
    logic [3:0] col;
  } dbo_slot_s;
  typedef enum logic [1:0] {PD_RUN = 2'b01, PD_DOWN = 2'b10} dbo_pd_e;
  localparam int PIPE = 16;

  dbo_slot_s pipe [PIPE];
  logic [dbo_pkg::DQ_W-1:0] mem [2**ADDR_W];
  dbo_pd_e state, next_state;
  logic busy, b_wr, b_is8, cke_q;
  logic [2:0] beat, b_bank;
  logic [3:0] b_col;
  logic [4:0] anpd;

  function automatic logic [ADDR_W-1:0] waddr(input logic [2:0] bk, input logic [3:0] cl, input logic [2:0] bt);
    return ADDR_W'({bk, cl[3], cl[2:0] + bt});
  endfunction : waddr

  ////////////////////////////////////////////////////////////////////////////
  wire logic [4:0] rl = dbo_pkg::read_lat(mode_al);
  wire logic [4:0] wl = dbo_pkg::write_lat(mode_al);
  wire logic awake = link.cke & (state == PD_RUN);
  wire logic is_wr = link.cmd == dbo_pkg::CMD_WR;
  wire logic col_cmd = awake & (is_wr | (link.cmd == dbo_pkg::CMD_RD));
  // Length picked per column command, never inherited from the last one
  wire logic is8_now = dbo_pkg::burst_is8(mode_burst, link.a12);
  // Two slots early so the pipe write and the registered outputs land exactly on the latency
  wire logic [3:0] ins = 4'((is_wr ? wl : rl) - 5'h02);
  wire logic start = pipe[0].v;
  wire logic next_busy = start | (busy & (beat != 3'h7));
  wire logic [2:0] next_beat = start ? 3'h0 : beat + 3'h1;
  wire logic next_wr = start ? pipe[0].wr : b_wr;
  wire logic next_is8 = start ? pipe[0].is8 : b_is8;
  wire logic [2:0] next_bank = start ? pipe[0].bank : b_bank;
  wire logic [3:0] next_col = start ? pipe[0].col : b_col;
  // Chopped reads leave the last four slots undriven
  wire logic drive_rd = next_busy & ~next_wr & (next_is8 | ~next_beat[2]);
  wire logic wr_beat = busy & b_wr & (b_is8 | ~beat[2]);
  wire logic cke_edge = cke_q != link.cke;
  logic rd_pending;

  always_comb begin
    rd_pending = 1'b0;
    for (int i = 0; i < PIPE; i++) begin
      rd_pending = rd_pending | (pipe[i].v & ~pipe[i].wr);
    end
  end

  always_comb begin
    case (state)
      PD_RUN: next_state = link.cke ? PD_RUN : PD_DOWN;
      PD_DOWN: next_state = link.cke ? PD_RUN : PD_DOWN;
      default: next_state = PD_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PIPE; i++) pipe[i] <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < PIPE - 1; i++) pipe[i] <= pipe[i + 1];
      pipe[PIPE - 1] <= '0;
      if (col_cmd) pipe[ins] <= '{1'b1, is_wr, is8_now, link.bank, link.col};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {busy, b_wr, b_is8, beat, b_bank, b_col} <= '0;
    end else if (clk_en) begin
      {busy, b_wr, b_is8} <= {next_busy, next_wr, next_is8};
      {beat, b_bank, b_col} <= {next_beat, next_bank, next_col};
    end
  end

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge core_clk) begin
    if (clk_en && wr_beat) mem[waddr(b_bank, b_col, beat)] <= link.dq;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.dram_dq <= '0;
      link.dram_dq_oe <= 1'b0;
      link.dram_dqs <= 1'b0;
      link.dram_dqs_oe <= 1'b0;
    end else if (clk_en) begin
      link.dram_dq <= drive_rd ? mem[waddr(next_bank, next_col, next_beat)] : '0;
      link.dram_dq_oe <= drive_rd;
      link.dram_dqs <= drive_rd & ~next_beat[0];
      // Strobe stays driven low across the gap while another read waits
      link.dram_dqs_oe <= drive_rd | (rd_pending & link.dram_dqs_oe);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= PD_RUN;
      cke_q <= 1'b1;
      anpd <= 5'h00;
      powered_down <= 1'b0;
      term_on <= 1'b0;
      term_dynamic <= 1'b0;
      term_uncertain <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      cke_q <= link.cke;
      anpd <= cke_edge ? wl - 5'h01 : (anpd != 5'h00 ? anpd - 5'h01 : 5'h00);
      powered_down <= next_state == PD_DOWN;
      term_on <= link.odt & awake;
      term_dynamic <= link.odt & next_busy & next_wr;
      term_uncertain <= cke_edge | (anpd > 5'h01);
    end
  end
endmodule : dbo_dram

// ==== sim/dbo_asserts.sv ====
// Protocol checker for the controller to memory link
`timescale 1ns/1ps
module dbo_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Mode settings
  input wire logic [1:0] mode_burst,
  input wire logic [1:0] mode_al,
  // Link
  input wire logic [2:0] cmd,
  input wire logic cke,
  input wire logic odt,
  input wire logic a12,
  input wire logic ctrl_dq_oe,
  input wire logic ctrl_dqs_oe,
  input wire logic dram_dq_oe,
  input wire logic dram_dqs_oe,
  input wire logic dqs
);
  ////////////////////////////////////////////////////////////////
  // Saturating ages; they start saturated so reset looks like a long quiet past
  logic [4:0] since_wr;
  logic [3:0] odt_age;
  wire is_wr = (cmd == dbo_pkg::CMD_WR) && cke;
  wire is_rd = (cmd == dbo_pkg::CMD_RD) && cke;
  wire full8 = (mode_burst == dbo_pkg::BURST_FIX8) || ((mode_burst == dbo_pkg::BURST_PER_CMD) && a12);
  wire al0 = (mode_al == dbo_pkg::AL_ZERO);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      since_wr <= 5'h1F;
      odt_age <= 4'hF;
    end else begin
      since_wr <= is_wr ? 5'h00 : (since_wr == 5'h1F ? since_wr : since_wr + 5'h01);
      odt_age <= !odt ? 4'h0 : (odt_age == 4'hF ? odt_age : odt_age + 4'h1);
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_WR_LAT: assert property (al0 && is_wr |-> ##5 ctrl_dq_oe) else $error("write data late or early");
  AST_RD_LAT: assert property (al0 && is_rd |-> ##4 !dram_dq_oe ##1 dram_dq_oe)
    else $error("read data not at latency five");
  AST_RD_AL2: assert property (mode_al == dbo_pkg::AL_CLM2 && is_rd |-> ##7 !dram_dq_oe ##1 dram_dq_oe)
    else $error("read data not at latency eight");
  AST_WR_FULL: assert property (al0 && is_wr && full8 |-> ##5 ctrl_dq_oe [*8])
    else $error("full write burst short");
  AST_WR_CHOP: assert property (al0 && is_wr && !full8 |-> ##5 ctrl_dq_oe [*4] ##1 !ctrl_dq_oe [*4])
    else $error("chopped write burst wrong length");
  AST_RD_FULL: assert property (al0 && is_rd && full8 |-> ##5 dram_dq_oe [*8])
    else $error("full read burst short");
  AST_RD_CHOP: assert property (al0 && is_rd && !full8 |-> ##9 !dram_dq_oe [*4])
    else $error("chopped read drives spare slots");
  AST_WTR: assert property (is_rd |-> since_wr >= 5'h0E) else $error("read too soon after write");
  AST_WREC: assert property (cmd == dbo_pkg::CMD_PRE && cke |-> since_wr >= 5'h0F)
    else $error("precharge too soon after write");
  AST_ODT_MIN: assert property ($fell(odt) |-> odt_age >= 4'h4) else $error("termination dropped early");
  AST_ODT_WR: assert property ($fell(odt) |-> since_wr >= 5'h05)
    else $error("termination dropped too soon after write");
  AST_PD_ENTRY: assert property ($fell(cke) |->
    $past(cmd) inside {dbo_pkg::CMD_NOP, dbo_pkg::CMD_DES, dbo_pkg::CMD_ACT, dbo_pkg::CMD_PRE})
    else $error("bad command before power-down");
  AST_PD_EXIT: assert property ($rose(cke) |-> (cmd inside {dbo_pkg::CMD_NOP, dbo_pkg::CMD_DES}) [*2])
    else $error("command too soon after exit");
  AST_PD_DLL: assert property ($rose(cke) |-> !(cmd inside {dbo_pkg::CMD_RD, dbo_pkg::CMD_WR}) [*4])
    else $error("column command before lock time");
  AST_DQS_LOW: assert property (dram_dqs_oe && !dram_dq_oe && !ctrl_dqs_oe |-> !dqs)
    else $error("strobe not low between reads");
endmodule : dbo_asserts

// ==== sim/dbo_test.sv ====
// Self-checking bench: controller and memory joined over the link
`timescale 1ns/1ps
module dbo_test;
  logic core_clk;
  logic reset_n;
  logic [1:0] mode_burst;
  logic [1:0] mode_al;
  logic odt_en;
  logic req_valid;
  logic req_ready;
  logic [1:0] req_op;
  logic req_chop;
  logic [2:0] req_bank;
  logic [3:0] req_col;
  logic [15:0] req_data;
  logic pd_req;
  logic in_powerdown;
  logic rd_valid;
  logic [15:0] rd_data;
  logic powered_down;
  logic term_on;
  logic term_dynamic;
  logic term_uncertain;
  logic [31:0] rnd;
  logic [2:0] b;
  logic [3:0] c;
  int failures;
  int comparisons;
  int acc;
  int e;
  int mem[int];
  int exp_q[$];
  dbo_if lnk();
  dbo_ctrl i_dbo_ctrl(.core_clk, .reset_n, .clk_en(1'b1), .mode_burst, .mode_al, .odt_en, .req_valid,
    .req_ready, .req_op, .req_chop, .req_bank, .req_col, .req_data, .pd_req, .in_powerdown, .rd_valid,
    .rd_data, .link(lnk));
  dbo_dram i_dbo_dram(.core_clk, .reset_n, .clk_en(1'b1), .mode_burst, .mode_al, .link(lnk),
    .powered_down, .term_on, .term_dynamic, .term_uncertain);
  dbo_asserts i_dbo_asserts(.core_clk, .reset_n, .mode_burst, .mode_al, .cmd(lnk.cmd), .cke(lnk.cke),
    .odt(lnk.odt), .a12(lnk.a12), .ctrl_dq_oe(lnk.ctrl_dq_oe), .ctrl_dqs_oe(lnk.ctrl_dqs_oe),
    .dram_dq_oe(lnk.dram_dq_oe), .dram_dqs_oe(lnk.dram_dqs_oe), .dqs(lnk.dqs));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int beats(input logic ch);
    return (mode_burst == dbo_pkg::BURST_FIX8 || (mode_burst == dbo_pkg::BURST_PER_CMD && !ch)) ? 8 : 4;
  endfunction : beats
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, expv, seen);
    end
  endtask : check
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // Model memory is filled as each request is driven, before it is accepted, so reads compare in issue order
  task automatic send(input logic [1:0] op, input logic ch, input logic [2:0] bk, input logic [3:0] cl);
    int a;
    @(posedge core_clk);
    rnd = lfsr(rnd);
    req_valid <= 1'b1;
    req_op <= op;
    req_chop <= ch;
    req_bank <= bk;
    req_col <= cl;
    req_data <= rnd[15:0];
    for (int i = 0; i < beats(ch); i++) begin
      a = {bk, cl[3], 3'(cl[2:0] + i)};
      if (op == 2'h1) mem[a] = 16'(rnd[15:0] + i);
      else if (op == 2'h0) exp_q.push_back(mem.exists(a) ? mem[a] : -1);
    end
    @(negedge core_clk);
    for (int k = 0; k < 400 && req_ready !== 1'b1; k++) @(negedge core_clk);
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask : send
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : -2;
      if (e != -1) check("rd_data", rd_data, e);
    end
    // Write data on the bus with termination enabled must see the write-time termination
    if (lnk.ctrl_dq_oe === 1'b1 && odt_en === 1'b1) check("term_dynamic", term_dynamic, 1);
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    close_out();
  end
  initial begin
    failures = 0;
    comparisons = 0;
    rnd = 32'hECBF856D;
    reset_n = 1'b0;
    {mode_burst, mode_al, odt_en, req_valid, req_op, req_chop, req_bank, req_col, pd_req} = '0;
    req_data = 16'h0000;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int m = 0; m < 9; m++) begin
      @(posedge core_clk);
      rnd = lfsr(rnd);
      mode_burst <= 2'(m % 3);
      mode_al <= 2'(m / 3);
      odt_en <= rnd[0];
      b = rnd[3:1];
      c = rnd[7:4];
      send(2'h2, 1'b0, b, c);
      send(2'h1, rnd[8], b, c);
      send(2'h1, rnd[9], b, c ^ 4'h8);
      send(2'h0, rnd[10], b, c);
      send(2'h0, rnd[11], b, c ^ 4'h8);
      send(2'h3, 1'b0, b, c);
      for (int k = 0; k < 400 && exp_q.size() != 0; k++) @(negedge core_clk);
      check("rd_left", exp_q.size(), 0);
      @(posedge core_clk);
      pd_req <= 1'b1;
      for (int k = 0; k < 400 && in_powerdown !== 1'b1; k++) @(negedge core_clk);
      @(negedge core_clk);
      check("cke", lnk.cke, 0);
      check("powered_down", powered_down, 1);
      check("uncertain", term_uncertain, 1);
      check("term_on", term_on, 0);
      // Queue must hold requests while asleep and refuse the ninth
      if (m == 8) begin
        acc = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_op <= 2'h2;
        for (int k = 0; k < 12; k++) begin
          @(negedge core_clk);
          if (req_ready === 1'b1) acc++;
          @(posedge core_clk);
        end
        req_valid <= 1'b0;
        check("queued", acc, 8);
      end
      @(posedge core_clk);
      pd_req <= 1'b0;
      for (int k = 0; k < 400 && in_powerdown !== 1'b0; k++) @(negedge core_clk);
      @(negedge core_clk);
      check("cke_back", lnk.cke, 1);
      $display("test burst mode %0d latency mode %0d done", m % 3, m / 3);
    end
    repeat (60) @(posedge core_clk);
    close_out();
  end
endmodule : dbo_test
